// [design/three_phase_gate_input_logic.v]
// Digital front end of a three-phase pre-driver: pin synchronisers,
// serial configuration, per-phase gate guards and status outputs.
// Assumes all pins are asynchronous to core_clk and the comparators
// arrive as digital levels from the analog section.
//
// Functional notes
// - Gate drives turn on only while both enable inputs are high.
// - Upper driver is requested while its phase command input is low.
// - Lower driver is requested while its phase command input is high.
// - Phase status output is low while its source is below half supply.
// - Host sends MSB first; device samples input on serial clock fall.
// - Serial output released while select is high, driven once it drops.
// - Low select frames a command; activity while high is ignored.
// - A serially written dead time guards each complementary turn-on unless overlap is enabled.
// - Simultaneous conduction needs a guarded two-frame serial sequence.
// - Overcurrent comparator result appears on its own output.
// - Asynchronous active-low reset; interrupt output to the host.
`include "three_phase_regs.vh"

module three_phase_gate_input_logic (
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // Enable inputs
    input wire drive_enable_first,
    input wire drive_enable_second,
    // Phase commands
    input wire phase_a_upper_cmd_n,
    input wire phase_b_upper_cmd_n,
    input wire phase_c_upper_cmd_n,
    input wire phase_a_lower_cmd,
    input wire phase_b_lower_cmd,
    input wire phase_c_lower_cmd,
    // Comparator levels: source node above half of load_supply, and overcurrent
    input wire phase_a_upper_source,
    input wire phase_b_upper_source,
    input wire phase_c_upper_source,
    input wire overcurrent_cmp,
    // Serial port
    input wire sclk,
    input wire cs_n,
    input wire si,
    output wire so_out,
    output wire so_oe_n,
    // Gate drive requests
    output wire phase_a_upper_gate,
    output wire phase_b_upper_gate,
    output wire phase_c_upper_gate,
    output wire phase_a_lower_gate,
    output wire phase_b_lower_gate,
    output wire phase_c_lower_gate,
    // Status to host
    output reg phase_a_switch_state,
    output reg phase_b_switch_state,
    output reg phase_c_switch_state,
    output reg overcurrent_flag,
    output reg interrupt_out
);

    // ==========================================================
    // Pin synchronisers
    localparam NUM_PINS = 15;
    localparam P_EN1 = 0;
    localparam P_EN2 = 1;
    localparam P_UPPER = 2;
    localparam P_LOWER = 5;
    localparam P_SRC = 8;
    localparam P_OC = 11;
    localparam P_SCLK = 12;
    localparam P_CS = 13;
    localparam P_SI = 14;

    wire [NUM_PINS-1:0] pin_async;
    reg [NUM_PINS-1:0] sync_s1;
    reg [NUM_PINS-1:0] sync_s2;

    assign pin_async = {si, cs_n, sclk, overcurrent_cmp,
        phase_c_upper_source, phase_b_upper_source, phase_a_upper_source,
        phase_c_lower_cmd, phase_b_lower_cmd, phase_a_lower_cmd,
        phase_c_upper_cmd_n, phase_b_upper_cmd_n, phase_a_upper_cmd_n,
        drive_enable_second, drive_enable_first};

    // Command pins idle in their off level so reset never asks for a gate;
    // select idles high so no frame is seen at release.
    localparam [NUM_PINS-1:0] SYNC_IDLE = 15'h201c;

    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g = g + 1) begin : g_sync
            always @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    sync_s1[g] <= SYNC_IDLE[g];
                    sync_s2[g] <= SYNC_IDLE[g];
                end else begin
                    sync_s1[g] <= pin_async[g];
                    sync_s2[g] <= sync_s1[g];
                end
            end
        end
    endgenerate

    // ==========================================================
    // Phase requests
    wire both_enabled;
    wire [2:0] upper_req;
    wire [2:0] lower_req;

    assign both_enabled = sync_s2[P_EN1] & sync_s2[P_EN2];
    assign upper_req = ~sync_s2[P_UPPER+2:P_UPPER];
    assign lower_req = sync_s2[P_LOWER+2:P_LOWER];

    // ==========================================================
    // Serial port
    wire frame_valid;
    wire [7:0] frame_data;
    wire frame_error;
    wire [7:0] status_byte;

    serial_setup_port u_serial (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .sclk_sync(sync_s2[P_SCLK]),
        .cs_n_sync(sync_s2[P_CS]),
        .si_sync(sync_s2[P_SI]),
        .status_byte(status_byte),
        .frame_valid(frame_valid),
        .frame_data(frame_data),
        .frame_error(frame_error),
        .so_out(so_out),
        .so_oe_n(so_oe_n)
    );

    // ==========================================================
    // Command decode
    function cmd_is;
        input [7:0] frame;
        input [2:0] code;
        begin
            cmd_is = (frame[`CMD_MSB:`CMD_LSB] == code);
        end
    endfunction

    wire [4:0] frame_arg;
    assign frame_arg = frame_data[`DATA_MSB:`DATA_LSB];

    // ==========================================================
    // Configuration
    reg [4:0] dead_time;
    reg overlap_enable;
    reg overlap_armed;
    wire clear_cmd;

    assign clear_cmd = frame_valid & cmd_is(frame_data, `CMD_CLEAR);

    // Any frame other than the key disarms, so a stray command between
    // the two halves of the sequence cannot leave overlap open.
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dead_time <= `DT_RESET;
            overlap_enable <= `OVERLAP_RESET;
            overlap_armed <= 1'b0;
        end else if (frame_valid) begin
            overlap_armed <= cmd_is(frame_data, `CMD_ARM) &&
                (frame_arg == `ARM_KEY);
            if (cmd_is(frame_data, `CMD_DEAD_TIME)) begin
                dead_time <= frame_arg;
            end
            if (cmd_is(frame_data, `CMD_OVERLAP_ON) && overlap_armed &&
                frame_arg == `OVERLAP_KEY) begin
                overlap_enable <= 1'b1;
            end else if (cmd_is(frame_data, `CMD_OVERLAP_OFF)) begin
                overlap_enable <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Dead-time scaling
    // One step rounds up to whole cycles so the guard is never short.
    localparam integer DT_STEP_INT =
        (`DT_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam [7:0] DT_STEP_CYC = DT_STEP_INT[7:0];
    wire [7:0] dead_cycles;

    assign dead_cycles = {3'h0, dead_time} * DT_STEP_CYC;

    // ==========================================================
    // Per-phase gate guards
    wire [2:0] upper_gate;
    wire [2:0] lower_gate;

    generate
        for (g = 0; g < 3; g = g + 1) begin : g_phase
            phase_gate_guard u_guard (
                .core_clk(core_clk),
                .rst_n(rst_n),
                .drive_enable(both_enabled),
                .upper_req(upper_req[g]),
                .lower_req(lower_req[g]),
                .overlap_allowed(overlap_enable),
                .dead_cycles(dead_cycles),
                .upper_gate(upper_gate[g]),
                .lower_gate(lower_gate[g])
            );
        end
    endgenerate

    assign phase_a_upper_gate = upper_gate[0];
    assign phase_b_upper_gate = upper_gate[1];
    assign phase_c_upper_gate = upper_gate[2];
    assign phase_a_lower_gate = lower_gate[0];
    assign phase_b_lower_gate = lower_gate[1];
    assign phase_c_lower_gate = lower_gate[2];

    // ==========================================================
    // Sticky events and interrupt
    reg oc_prev;
    reg oc_latch;
    reg ferr_latch;
    wire oc_rise;

    assign oc_rise = sync_s2[P_OC] & ~oc_prev;

    // A new event in the clearing cycle keeps its flag set
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            oc_prev <= 1'b0;
            oc_latch <= 1'b0;
            ferr_latch <= 1'b0;
            interrupt_out <= 1'b0;
        end else begin
            oc_prev <= sync_s2[P_OC];
            oc_latch <= oc_rise | (oc_latch & ~clear_cmd);
            ferr_latch <= frame_error | (ferr_latch & ~clear_cmd);
            interrupt_out <= oc_latch | ferr_latch;
        end
    end

    // ==========================================================
    // Status outputs
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_a_switch_state <= 1'b0;
            phase_b_switch_state <= 1'b0;
            phase_c_switch_state <= 1'b0;
            overcurrent_flag <= 1'b0;
        end else begin
            phase_a_switch_state <= sync_s2[P_SRC];
            phase_b_switch_state <= sync_s2[P_SRC+1];
            phase_c_switch_state <= sync_s2[P_SRC+2];
            overcurrent_flag <= sync_s2[P_OC];
        end
    end

    // Status byte, sampled by the serial port at select fall
    assign status_byte = {oc_latch, ferr_latch, overlap_enable,
        phase_c_switch_state, phase_b_switch_state, phase_a_switch_state,
        both_enabled, overlap_armed};

endmodule // three_phase_gate_input_logic

// [include/three_phase_regs.vh]
// Constants of the three-phase gate input logic: timing, serial frame
// layout, command codes, keys, status bit positions and reset values.
// Assumes inclusion by bare name from the design files.
`ifndef THREE_PHASE_REGS_VH
`define THREE_PHASE_REGS_VH

// ==========================================================
// Timing
`define CLK_PERIOD_NS 25
`define DT_STEP_NS 50

// ==========================================================
// Serial frame layout
`define FRAME_BITS 4'h8
`define CNT_SAT 4'hf
`define CMD_MSB 7
`define CMD_LSB 5
`define DATA_MSB 4
`define DATA_LSB 0

// ==========================================================
// Command codes
`define CMD_NOP 3'h0
`define CMD_DEAD_TIME 3'h1
`define CMD_ARM 3'h2
`define CMD_OVERLAP_ON 3'h3
`define CMD_CLEAR 3'h4
`define CMD_OVERLAP_OFF 3'h5

// ==========================================================
// Guard keys for the simultaneous-conduction sequence
`define ARM_KEY 5'h15
`define OVERLAP_KEY 5'h0a

// ==========================================================
// Status byte bit positions
`define ST_OVERCURRENT 7
`define ST_FRAME_ERR 6
`define ST_OVERLAP 5
`define ST_PHASE_C 4
`define ST_PHASE_B 3
`define ST_PHASE_A 2
`define ST_ENABLED 1
`define ST_ARMED 0

// ==========================================================
// Reset values
`define DT_RESET 5'h04
`define OVERLAP_RESET 1'b0

`endif

// [design/phase_gate_guard.v]
// One phase: turns the upper and lower requests into gate drives.
// Assumes synchronised requests and a stable dead-time count.
`include "three_phase_regs.vh"

module phase_gate_guard (
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // Requests and configuration
    input wire drive_enable,
    input wire upper_req,
    input wire lower_req,
    input wire overlap_allowed,
    input wire [7:0] dead_cycles,
    // Gate drives
    output reg upper_gate,
    output reg lower_gate
);

    // ==========================================================
    // Request qualification
    reg [7:0] guard;
    wire want_upper;
    wire want_lower;
    wire next_upper;
    wire next_lower;
    wire guard_free;

    // Unless overlap is allowed, a phase asked for both switches is shut, not raced
    assign want_upper = drive_enable & upper_req &
        (overlap_allowed | ~lower_req);
    assign want_lower = drive_enable & lower_req &
        (overlap_allowed | ~upper_req);
    assign guard_free = (guard == 8'h00);

    // Turn-off is immediate; turn-on waits out the guard interval unless overlap is allowed
    assign next_upper = want_upper & (upper_gate | overlap_allowed |
        (~lower_gate & guard_free));
    assign next_lower = want_lower & (lower_gate | overlap_allowed |
        (~upper_gate & guard_free));

    // ==========================================================
    // Gate state and guard counter
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            upper_gate <= 1'b0;
            lower_gate <= 1'b0;
            guard <= 8'h00;
        end else begin
            upper_gate <= next_upper;
            lower_gate <= next_lower;
            if ((upper_gate & ~next_upper) | (lower_gate & ~next_lower)) begin
                guard <= dead_cycles;
            end else if (!guard_free) begin
                guard <= guard - 8'h01;
            end
        end
    end

endmodule // phase_gate_guard

// [design/serial_setup_port.v]
// Serial setup port: receives 8-bit frames MSB first, returns a status
// byte on the serial output. Assumes synchronised pin levels, and a
// serial clock far slower than the core clock.
`include "three_phase_regs.vh"

module serial_setup_port (
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // Synchronised serial pins
    input wire sclk_sync,
    input wire cs_n_sync,
    input wire si_sync,
    // Status to send
    input wire [7:0] status_byte,
    // Received frames
    output reg frame_valid,
    output reg [7:0] frame_data,
    output reg frame_error,
    // Serial output pin
    output reg so_out,
    output reg so_oe_n
);

    // ==========================================================
    // Edge detection on the synchronised pins
    reg sclk_prev;
    reg cs_prev;
    reg [7:0] shift_in;
    reg [7:0] shift_out;
    reg [3:0] bit_cnt;
    wire sclk_fall;
    wire sclk_rise;
    wire cs_fall;
    wire cs_rise;

    assign sclk_fall = sclk_prev & ~sclk_sync;
    assign sclk_rise = ~sclk_prev & sclk_sync;
    assign cs_fall = cs_prev & ~cs_n_sync;
    assign cs_rise = ~cs_prev & cs_n_sync;

    // ==========================================================
    // Frame engine
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_prev <= 1'b0;
            cs_prev <= 1'b1;
            shift_in <= 8'h00;
            shift_out <= 8'h00;
            bit_cnt <= 4'h0;
            frame_valid <= 1'b0;
            frame_data <= 8'h00;
            frame_error <= 1'b0;
            so_out <= 1'b0;
            so_oe_n <= 1'b1;
        end else begin
            sclk_prev <= sclk_sync;
            cs_prev <= cs_n_sync;
            frame_valid <= 1'b0;
            frame_error <= 1'b0;
            if (cs_fall) begin
                bit_cnt <= 4'h0;
                shift_out <= status_byte;
                so_out <= status_byte[7];
                so_oe_n <= 1'b0;
            end else if (cs_rise) begin
                so_oe_n <= 1'b1;
                so_out <= 1'b0;
                // Short or long frames are dropped whole
                if (bit_cnt == `FRAME_BITS) begin
                    frame_valid <= 1'b1;
                    frame_data <= shift_in;
                end else begin
                    frame_error <= 1'b1;
                end
            end else if (!cs_n_sync) begin
                if (sclk_fall) begin
                    shift_in <= {shift_in[6:0], si_sync};
                    if (bit_cnt != `CNT_SAT) begin
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                end
                // A leading rising edge before any bit is not a shift
                if (sclk_rise && bit_cnt != 4'h0) begin
                    shift_out <= {shift_out[6:0], 1'b0};
                    so_out <= shift_out[6];
                end
            end
        end
    end

endmodule // serial_setup_port

// [tb/three_phase_gate_input_logic_monitor.sv]
// Concurrent checks on the pins of the gate input logic.
// Assumes pins move just after core_clk rises; pin to output is 3 edges.
module gate_logic_monitor (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Inputs watched
    input wire logic drive_enable_first,
    input wire logic drive_enable_second,
    input wire logic phase_a_upper_cmd_n,
    input wire logic phase_a_lower_cmd,
    input wire logic phase_a_upper_source,
    input wire logic overcurrent_cmp,
    input wire logic cs_n,
    // Outputs watched
    input wire logic so_out,
    input wire logic so_oe_n,
    input wire logic phase_a_upper_gate,
    input wire logic phase_b_upper_gate,
    input wire logic phase_c_upper_gate,
    input wire logic phase_a_lower_gate,
    input wire logic phase_b_lower_gate,
    input wire logic phase_c_lower_gate,
    input wire logic phase_a_switch_state,
    input wire logic overcurrent_flag,
    input wire logic interrupt_out
);
    timeunit 1ns;
    timeprecision 1ps;
    wire [5:0] gates = {phase_a_upper_gate, phase_b_upper_gate,
        phase_c_upper_gate, phase_a_lower_gate, phase_b_lower_gate,
        phase_c_lower_gate};
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // Gate drives
    chk_enable_gates_off: assert property (
        (!(drive_enable_first && drive_enable_second)) [*4] |-> gates == 0)
        else $error("gate on with an enable low");
    chk_upper_needs_cmd: assert property (
        $rose(phase_a_upper_gate) |-> !$past(phase_a_upper_cmd_n, 3))
        else $error("upper gate rose without low command");
    chk_lower_needs_cmd: assert property (
        $rose(phase_a_lower_gate) |-> $past(phase_a_lower_cmd, 3))
        else $error("lower gate rose without high command");
    chk_reset_all_off: assert property (
        $rose(rst_n) |-> gates == 0 && so_oe_n && !interrupt_out)
        else $error("outputs active right after reset");
    // ==========================================================
    // Status and serial output
    chk_state_copy: assert property (
        phase_a_switch_state == $past(phase_a_upper_source, 3))
        else $error("phase state does not follow comparator");
    chk_overcurrent_copy: assert property (
        overcurrent_flag == $past(overcurrent_cmp, 3))
        else $error("overcurrent flag does not follow comparator");
    chk_so_released: assert property (
        cs_n [*4] |-> so_oe_n && !so_out)
        else $error("serial output driven while deselected");
    chk_so_after_select: assert property (
        $fell(so_oe_n) |-> !$past(cs_n))
        else $error("serial output driven before select");
    chk_int_on_overcurrent: assert property (
        $rose(overcurrent_flag) |-> ##[0:3] interrupt_out)
        else $error("no interrupt after overcurrent");
endmodule // gate_logic_monitor

// [tb/host_serial_model.sv]
// Host side of the serial setup port: frames, clocks and shifts bits.
// Assumes a 40 MHz core_clk; the serial clock idles high between frames.
module host_serial_model (
    // Clock
    input wire logic core_clk,
    // Serial pins
    output logic sclk,
    output logic cs_n,
    output logic si,
    input wire logic so_line
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        si = 1'b0;
    end
    // Half of a 200 ns serial period
    task automatic half_bit();
        repeat (4) @(posedge core_clk);
    endtask
    // ==========================================================
    // One frame; returned data is caught at each serial clock fall
    task automatic frame(input logic [7:0] d, input int nbits,
                         output logic [7:0] rx);
        rx = 8'h00;
        @(posedge core_clk);
        cs_n <= 1'b0;
        half_bit();
        for (int i = 0; i < nbits; i++) begin
            si <= d[7 - i];
            half_bit();
            sclk <= 1'b0;
            rx = {rx[6:0], so_line};
            half_bit();
            sclk <= 1'b1;
        end
        half_bit();
        cs_n <= 1'b1;
        // Stale data would look valid, so leave the line changed
        si <= ~si;
        repeat (8) @(posedge core_clk);
    endtask
endmodule // host_serial_model

// [tb/tb_three_phase_gate_input_logic.sv]
// Self-checking bench of the gate input logic with a host serial model.
// Assumes the design, its header and the monitor are compiled first.
module tb_three_phase_gate_input_logic;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, rst_n, en_first, en_second, oc_cmp;
    logic [2:0] upper_cmd_n, lower_cmd, upper_source;
    wire sclk, cs_n, si, so_out, so_oe_n, oc_flag, irq;
    wire [2:0] upper_gate, lower_gate, switch_state;
    wire so_line = so_oe_n ? 1'bz : so_out;
    int n_fail = 0;
    int checks = 0;
    int n0, n1, n2;
    logic [7:0] rx;

    three_phase_gate_input_logic u_three_phase_gate_input_logic (
        .core_clk(core_clk), .rst_n(rst_n),
        .drive_enable_first(en_first), .drive_enable_second(en_second),
        .phase_a_upper_cmd_n(upper_cmd_n[0]),
        .phase_b_upper_cmd_n(upper_cmd_n[1]),
        .phase_c_upper_cmd_n(upper_cmd_n[2]),
        .phase_a_lower_cmd(lower_cmd[0]), .phase_b_lower_cmd(lower_cmd[1]),
        .phase_c_lower_cmd(lower_cmd[2]),
        .phase_a_upper_source(upper_source[0]),
        .phase_b_upper_source(upper_source[1]),
        .phase_c_upper_source(upper_source[2]),
        .overcurrent_cmp(oc_cmp), .sclk(sclk), .cs_n(cs_n), .si(si),
        .so_out(so_out), .so_oe_n(so_oe_n),
        .phase_a_upper_gate(upper_gate[0]),
        .phase_b_upper_gate(upper_gate[1]),
        .phase_c_upper_gate(upper_gate[2]),
        .phase_a_lower_gate(lower_gate[0]),
        .phase_b_lower_gate(lower_gate[1]),
        .phase_c_lower_gate(lower_gate[2]),
        .phase_a_switch_state(switch_state[0]),
        .phase_b_switch_state(switch_state[1]),
        .phase_c_switch_state(switch_state[2]),
        .overcurrent_flag(oc_flag), .interrupt_out(irq));

    host_serial_model u_host_serial_model (.core_clk(core_clk),
        .sclk(sclk), .cs_n(cs_n), .si(si), .so_line(so_line));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // ==========================================================
    // Shared helpers
    task automatic tally_and_finish();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic compare(logic [7:0] got, logic [7:0] exp, string what);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got,
                exp);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic send(logic [7:0] d);
        logic [7:0] unused;
        u_host_serial_model.frame(d, 8, unused);
    endtask
    function automatic logic [7:0] gate_byte();
        return {2'b00, upper_gate, lower_gate};
    endfunction
    function automatic logic [7:0] pair_a();
        return {6'h00, upper_gate[0], lower_gate[0]};
    endfunction
    function automatic logic [7:0] pin_byte();
        return {3'b000, switch_state, oc_flag, irq};
    endfunction
    // ==========================================================
    // Scenarios
    task automatic t_enables();
        lower_cmd <= 3'b111;
        for (int i = 0; i < 4; i++) begin
            en_first <= i[0];
            en_second <= i[1];
            tick(6);
            compare(gate_byte(), i == 3 ? 8'h07 : 8'h00, "en");
        end
    endtask
    task automatic t_polarity();
        lower_cmd <= 3'b000;
        upper_cmd_n <= 3'b000;
        tick(20);
        compare(gate_byte(), 8'h38, "upper on");
        upper_cmd_n <= 3'b101;
        lower_cmd <= 3'b100;
        tick(20);
        compare(gate_byte(), 8'h14, "mixed");
    endtask
    // Edges from phase a lower to upper hand-over until upper is on
    task automatic t_dead(output int n);
        upper_cmd_n <= 3'b111;
        lower_cmd <= 3'b001;
        tick(20);
        upper_cmd_n <= 3'b110;
        lower_cmd <= 3'b000;
        n = 0;
        while (upper_gate[0] !== 1'b1) begin
            @(posedge core_clk);
            n++;
            if (n > 200) begin
                compare(8'h00, 8'h01, "upper gate timeout");
                tally_and_finish();
            end
        end
    endtask
    task automatic t_overlap();
        upper_cmd_n <= 3'b110;
        lower_cmd <= 3'b001;
        tick(20);
        compare(pair_a(), 8'h00, "both");
        send(8'h55);
        send(8'h00);
        send(8'h6a);
        tick(4);
        compare(pair_a(), 8'h00, "key");
        send(8'h55);
        send(8'h6a);
        tick(4);
        compare(pair_a(), 8'h03, "on");
        send(8'ha0);
        tick(4);
        compare(pair_a(), 8'h00, "off");
    endtask
    task automatic t_status();
        upper_source <= 3'b011;
        oc_cmp <= 1'b1;
        tick(8);
        compare(pin_byte(), 8'h0f, "pins");
        u_host_serial_model.frame(8'h00, 8, rx);
        compare(rx, 8'h8e, "status");
        send(8'h80);
        tick(4);
        compare({7'h00, irq}, 8'h00, "cleared");
        oc_cmp <= 1'b0;
        u_host_serial_model.frame(8'h21, 5, rx);
        tick(4);
        compare({7'h00, irq}, 8'h01, "short frame");
        u_host_serial_model.frame(8'h00, 8, rx);
        compare(rx, 8'h4e, "frame error");
        send(8'h80);
        upper_source <= 3'b000;
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        rst_n = 1'b0;
        en_first = 1'b0;
        en_second = 1'b0;
        oc_cmp = 1'b0;
        upper_cmd_n = 3'b111;
        lower_cmd = 3'b000;
        upper_source = 3'b000;
        tick(20);
        rst_n <= 1'b1;
        tick(4);
        compare(gate_byte(), 8'h00, "reset gates");
        compare({6'h00, so_oe_n, irq}, 8'h02, "reset pins");
        t_enables();
        t_polarity();
        t_dead(n0);
        send(8'h21);
        t_dead(n1);
        compare(8'(n0 - n1), 8'h06, "dead time");
        rst_n <= 1'b0;
        tick(3);
        compare(gate_byte(), 8'h00, "mid reset");
        rst_n <= 1'b1;
        tick(4);
        t_dead(n2);
        compare(8'(n2), 8'(n0), "dead time default");
        t_overlap();
        t_status();
        tally_and_finish();
    end
endmodule // tb_three_phase_gate_input_logic

bind three_phase_gate_input_logic gate_logic_monitor u_gate_logic_monitor (
    .core_clk(core_clk), .rst_n(rst_n),
    .drive_enable_first(drive_enable_first),
    .drive_enable_second(drive_enable_second),
    .phase_a_upper_cmd_n(phase_a_upper_cmd_n),
    .phase_a_lower_cmd(phase_a_lower_cmd),
    .phase_a_upper_source(phase_a_upper_source),
    .overcurrent_cmp(overcurrent_cmp), .cs_n(cs_n), .so_out(so_out),
    .so_oe_n(so_oe_n), .phase_a_upper_gate(phase_a_upper_gate),
    .phase_b_upper_gate(phase_b_upper_gate),
    .phase_c_upper_gate(phase_c_upper_gate),
    .phase_a_lower_gate(phase_a_lower_gate),
    .phase_b_lower_gate(phase_b_lower_gate),
    .phase_c_lower_gate(phase_c_lower_gate),
    .phase_a_switch_state(phase_a_switch_state),
    .overcurrent_flag(overcurrent_flag), .interrupt_out(interrupt_out));
